// >>> hdl/agp_rq_pkg.sv
package agp_rq_pkg;
    localparam int AD_W = 32;
    localparam int SB_W = 8;
    localparam int ST_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int HALF_W = 16;
    localparam int DBI_LIMIT = 8;
    localparam int SB_BYTES = 4;
    localparam int SYNC_N = 3;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_QUEUE = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0C;
    localparam logic [7:0] OFS_TXSTAT = 8'h10;
    localparam logic [7:0] OFS_RXDATA = 8'h14;

    localparam int ST_CNT_LSB = 0;
    localparam int ST_EMPTY = 4;
    localparam int ST_FULL = 5;
    localparam int ST_OVF = 6;
    localparam int ST_HEADSRC = 7;

    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [SB_W-1:0] SB_IDLE = 8'hFF;
    localparam logic [ST_W-1:0] STAT_LP_READ = 3'h0;
    localparam logic [ST_W-1:0] STAT_IDLE = 3'h7;

    typedef struct packed {
        logic locked;
        logic sidebandSel;
        logic sidebandEn;
        logic rate8x;
        logic mode3;
    } ctrl_t;

    typedef struct packed {
        logic fromSideband;
        logic [AD_W-1:0] addr;
    } request_t;

    localparam int REQ_W = AD_W + 1;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_GRANT = 2'b01,
        TX_DRIVE = 2'b11,
        TX_RELEASE = 2'b10
    } tx_state_t;
endpackage

// >>> hdl/agp_request_queue.sv
`timescale 1ns/1ps

module request_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign inReady = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign count = count_q;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + AW'(1);
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule // request_fifo

module agp_request_queue (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic portClk,
    input wire logic pipelinedRequestNIn,
    output logic pipelinedRequestNOut,
    output logic pipelinedRequestNOe,
    input wire logic [agp_rq_pkg::AD_W-1:0] portAddrDataBusIn,
    output logic [agp_rq_pkg::AD_W-1:0] portAddrDataBusOut,
    output logic portAddrDataBusOe,
    output logic upperStrobeFirst,
    output logic upperStrobeSecond,
    input wire logic [agp_rq_pkg::SB_W-1:0] sidebandAddrBus,
    output logic sidebandPullupEn,
    output logic portGrantN,
    output logic [agp_rq_pkg::ST_W-1:0] arbiterStatusCode
);
    localparam int AW = agp_rq_pkg::AD_W;
    localparam int HW = agp_rq_pkg::HALF_W;
    localparam int SW = agp_rq_pkg::SB_W;
    localparam int NS = agp_rq_pkg::SYNC_N;

    function automatic logic [4:0] popCount16(input logic [HW-1:0] v);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < HW; i++) begin
            n = n + 5'(v[i]);
        end
        return n;
    endfunction

    function automatic logic [HW-1:0] undoInvert(input logic [HW-1:0] v,
                                                  input logic flag);
        return flag ? ~v : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb slave
    agp_rq_pkg::ctrl_t ctrl_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic ovf_q;
    logic [AW-1:0] txData_q;
    logic [AW-1:0] rxData_q;
    logic txStart;
    logic popReq;
    logic accessDone;
    logic mapped;
    logic [31:0] rdMux;
    agp_rq_pkg::tx_state_t txState_q;
    logic qOutValid;
    agp_rq_pkg::request_t qOut;
    logic [agp_rq_pkg::CNT_W-1:0] qCount;
    logic ovfSet;

    assign accessDone = psel && penable && pready_q;
    assign txStart = accessDone && pwrite && (paddr == agp_rq_pkg::OFS_TXDATA)
                     && (txState_q == agp_rq_pkg::TX_IDLE);
    assign popReq = accessDone && !pwrite
                    && (paddr == agp_rq_pkg::OFS_QUEUE);

    always_comb begin
        mapped = 1'b1;
        rdMux = '0;
        unique case (paddr)
            agp_rq_pkg::OFS_CTRL: rdMux = 32'(ctrl_q);
            agp_rq_pkg::OFS_STATUS: begin
                rdMux[agp_rq_pkg::ST_CNT_LSB +: agp_rq_pkg::CNT_W] = qCount;
                rdMux[agp_rq_pkg::ST_EMPTY] = !qOutValid;
                rdMux[agp_rq_pkg::ST_FULL] =
                    (qCount == agp_rq_pkg::CNT_W'(agp_rq_pkg::FIFO_DEPTH));
                rdMux[agp_rq_pkg::ST_OVF] = ovf_q;
                rdMux[agp_rq_pkg::ST_HEADSRC] =
                    qOutValid && qOut.fromSideband;
            end
            agp_rq_pkg::OFS_QUEUE: rdMux = qOutValid ? qOut.addr : '0;
            agp_rq_pkg::OFS_TXDATA: rdMux = txData_q;
            agp_rq_pkg::OFS_RXDATA: rdMux = rxData_q;
            agp_rq_pkg::OFS_TXSTAT:
                rdMux = 32'(txState_q != agp_rq_pkg::TX_IDLE);
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q <= (psel && penable && !pready_q && !pwrite)
                        ? rdMux : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= agp_rq_pkg::ctrl_t'(agp_rq_pkg::CTRL_RESET);
        end else if (accessDone && pwrite
                     && paddr == agp_rq_pkg::OFS_CTRL) begin
            if (!ctrl_q.locked) begin
                ctrl_q <= agp_rq_pkg::ctrl_t'(pwdata[4:0]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txData_q <= '0;
        end else if (txStart) begin
            txData_q <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (ovfSet) begin
            ovf_q <= 1'b1;
        end else if (accessDone && pwrite && paddr == agp_rq_pkg::OFS_STATUS
                     && pwdata[agp_rq_pkg::ST_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // link input sampling
    logic [NS-1:0] clkSync_q;
    logic [NS-1:0] pipeSync_q;
    logic [AW-1:0] adSync_q [NS];
    logic [SW-1:0] sbSync_q [NS];
    logic linkLevel_q;
    logic linkRise;

    always_ff @(posedge clk) begin
        if (rst) begin
            // parked high so no false rise follows reset
            clkSync_q <= '1;
            pipeSync_q <= '1;
            for (int i = 0; i < NS; i++) begin
                adSync_q[i] <= '0;
                sbSync_q[i] <= agp_rq_pkg::SB_IDLE;
            end
        end else begin
            clkSync_q <= {clkSync_q[NS-2:0], portClk};
            pipeSync_q <= {pipeSync_q[NS-2:0], pipelinedRequestNIn};
            adSync_q[0] <= portAddrDataBusIn;
            sbSync_q[0] <= sidebandAddrBus;
            for (int i = 1; i < NS; i++) begin
                adSync_q[i] <= adSync_q[i-1];
                sbSync_q[i] <= sbSync_q[i-1];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            linkLevel_q <= 1'b1;
        end else if (clkSync_q[1] == clkSync_q[2]) begin
            linkLevel_q <= clkSync_q[2];
        end
    end

    assign linkRise = (clkSync_q[1] == clkSync_q[2]) && clkSync_q[2]
                      && !linkLevel_q;

    ////////////////////////////////////////////////////////////////////////
    // request capture
    logic pipeReq;
    logic dbiFlag;
    logic [AW-1:0] rxWord;
    logic sbAllowed;
    logic [SW-1:0] sbByte;
    logic sbValid;
    logic [AW-1:0] sbAsm_q;
    logic [1:0] sbIdx_q;
    logic sbPend_q;
    logic fifoInValid;
    logic fifoInReady;
    agp_rq_pkg::request_t fifoIn;

    assign pipeReq = linkRise && !pipeSync_q[2] && !ctrl_q.mode3
                     && !ctrl_q.sidebandSel;
    assign dbiFlag = ctrl_q.mode3 && pipeSync_q[2];
    assign rxWord = {undoInvert(adSync_q[2][AW-1:HW], dbiFlag),
                     adSync_q[2][HW-1:0]};

    // last received word, inversion undone
    always_ff @(posedge clk) begin
        if (rst) begin
            rxData_q <= '0;
        end else if (linkRise) begin
            rxData_q <= rxWord;
        end
    end

    assign sbAllowed = ctrl_q.sidebandSel
                       && (ctrl_q.mode3 || ctrl_q.sidebandEn);
    assign sbByte = ctrl_q.mode3 ? ~sbSync_q[2] : sbSync_q[2];
    assign sbValid = linkRise && sbAllowed
                     && (sbSync_q[2] != agp_rq_pkg::SB_IDLE) && !sbPend_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sbAsm_q <= '0;
            sbIdx_q <= '0;
            sbPend_q <= 1'b0;
        end else begin
            if (sbValid) begin
                sbAsm_q[sbIdx_q*SW +: SW] <= sbByte;
                sbIdx_q <= sbIdx_q + 2'(1);
                sbPend_q <= (sbIdx_q == 2'(agp_rq_pkg::SB_BYTES - 1));
            end else if (sbPend_q && fifoInReady && !pipeReq) begin
                sbPend_q <= 1'b0;
            end
        end
    end

    always_comb begin
        fifoIn.fromSideband = 1'b0;
        fifoIn.addr = rxWord;
        fifoInValid = pipeReq;
        if (!pipeReq && sbPend_q) begin
            fifoIn.fromSideband = 1'b1;
            fifoIn.addr = sbAsm_q;
            fifoInValid = 1'b1;
        end
    end

    assign ovfSet = pipeReq && !fifoInReady;

    request_fifo #(
        .WIDTH(agp_rq_pkg::REQ_W),
        .DEPTH(agp_rq_pkg::FIFO_DEPTH),
        .CW(agp_rq_pkg::CNT_W)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(qOutValid),
        .outReady(popReq),
        .outData(qOut),
        .count(qCount)
    );

    ////////////////////////////////////////////////////////////////////////
    // return path
    logic [HW-1:0] lastUpper_q;
    logic txInvert;
    logic sbPullup_q;
    logic grantN_q;
    logic [agp_rq_pkg::ST_W-1:0] status_q;
    logic [AW-1:0] adOut_q;
    logic adOe_q;
    logic dbiOut_q;
    logic dbiOe_q;
    logic strobe_q;
    logic strobeSecond_q;

    assign txInvert = ctrl_q.mode3 && ctrl_q.rate8x
        && (popCount16(txData_q[AW-1:HW] ^ lastUpper_q)
            > 5'(agp_rq_pkg::DBI_LIMIT));

    always_ff @(posedge clk) begin
        if (rst) begin
            txState_q <= agp_rq_pkg::TX_IDLE;
        end else begin
            unique case (txState_q)
                agp_rq_pkg::TX_IDLE:
                    if (txStart) begin
                        txState_q <= agp_rq_pkg::TX_GRANT;
                    end
                agp_rq_pkg::TX_GRANT:
                    if (linkRise) begin
                        txState_q <= agp_rq_pkg::TX_DRIVE;
                    end
                agp_rq_pkg::TX_DRIVE:
                    if (linkRise) begin
                        txState_q <= agp_rq_pkg::TX_RELEASE;
                    end
                agp_rq_pkg::TX_RELEASE:
                    if (linkRise) begin
                        txState_q <= agp_rq_pkg::TX_IDLE;
                    end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            grantN_q <= 1'b1;
            status_q <= agp_rq_pkg::STAT_IDLE;
        end else begin
            grantN_q <= (txState_q == agp_rq_pkg::TX_IDLE);
            status_q <= (txState_q == agp_rq_pkg::TX_IDLE)
                        ? agp_rq_pkg::STAT_IDLE : agp_rq_pkg::STAT_LP_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adOut_q <= '0;
            adOe_q <= 1'b0;
            dbiOut_q <= 1'b0;
            dbiOe_q <= 1'b0;
            strobe_q <= 1'b0;
            strobeSecond_q <= 1'b1;
            lastUpper_q <= '0;
        end else if (txState_q == agp_rq_pkg::TX_GRANT && linkRise) begin
            adOut_q <= {txInvert ? ~txData_q[AW-1:HW] : txData_q[AW-1:HW],
                        txData_q[HW-1:0]};
            lastUpper_q <= txInvert ? ~txData_q[AW-1:HW] : txData_q[AW-1:HW];
            adOe_q <= 1'b1;
            dbiOut_q <= txInvert;
            dbiOe_q <= ctrl_q.mode3;
            strobe_q <= 1'b1;
            strobeSecond_q <= 1'b0;
        end else if (txState_q == agp_rq_pkg::TX_DRIVE && linkRise) begin
            adOe_q <= 1'b0;
            dbiOe_q <= 1'b0;
            dbiOut_q <= 1'b0;
            strobe_q <= 1'b0;
            strobeSecond_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sbPullup_q <= 1'b0;
        end else begin
            sbPullup_q <= ctrl_q.sidebandEn;
        end
    end

    assign portAddrDataBusOut = adOut_q;
    assign portAddrDataBusOe = adOe_q;
    assign pipelinedRequestNOut = dbiOut_q;
    assign pipelinedRequestNOe = dbiOe_q;
    assign upperStrobeFirst = strobe_q;
    assign upperStrobeSecond = strobeSecond_q;
    assign sidebandPullupEn = sbPullup_q;
    assign portGrantN = grantN_q;
    assign arbiterStatusCode = status_q;
endmodule // agp_request_queue

// >>> bench/agp_request_queue_asserts.sv
`timescale 1ns/1ps
module agp_request_queue_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pipelinedRequestNOe,
    input wire logic portAddrDataBusOe,
    input wire logic upperStrobeFirst,
    input wire logic upperStrobeSecond,
    input wire logic sidebandPullupEn,
    input wire logic portGrantN,
    input wire logic [agp_rq_pkg::ST_W-1:0] arbiterStatusCode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held too long");
    property p_ready_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer)
        else $error("pready late");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("prdata not zero");
    property p_status_code;
        arbiterStatusCode == (portGrantN ? agp_rq_pkg::STAT_IDLE
            : agp_rq_pkg::STAT_LP_READ);
    endproperty
    a_status_code: assert property (p_status_code)
        else $error("status code wrong");
    property p_flag_oe;
        pipelinedRequestNOe |-> portAddrDataBusOe;
    endproperty
    a_flag_oe: assert property (p_flag_oe)
        else $error("flag driven outside return");
    property p_strobe;
        portAddrDataBusOe |-> upperStrobeFirst && !upperStrobeSecond;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe pair wrong");
    property p_oe_grant;
        portAddrDataBusOe |-> !portGrantN;
    endproperty
    a_oe_grant: assert property (p_oe_grant)
        else $error("bus driven without grant");
    property p_drive_hold;
        $rose(portAddrDataBusOe) |-> portAddrDataBusOe[*4];
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("drive too short");
    property p_reset_vals;
        $fell(rst) |-> portGrantN && !pready && !portAddrDataBusOe
            && !sidebandPullupEn && !pipelinedRequestNOe;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");
    c_err: cover property (pslverr);
    c_drive: cover property ($rose(portAddrDataBusOe));
    c_pullup: cover property ($rose(sidebandPullupEn));
endmodule // agp_request_queue_asserts

bind agp_request_queue agp_request_queue_asserts chk (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .pipelinedRequestNOe(pipelinedRequestNOe),
    .portAddrDataBusOe(portAddrDataBusOe),
    .upperStrobeFirst(upperStrobeFirst),
    .upperStrobeSecond(upperStrobeSecond),
    .sidebandPullupEn(sidebandPullupEn), .portGrantN(portGrantN),
    .arbiterStatusCode(arbiterStatusCode));

// >>> bench/agp_master_model.sv
`timescale 1ns/1ps
module agp_master_model (
    input wire logic clk,
    output logic portClk,
    output logic pipeN,
    output logic [31:0] bus,
    output logic [7:0] sba
);
    initial begin
        portClk = 1'b0;
        pipeN = 1'b1;
        bus = 32'h0000_0000;
        sba = agp_rq_pkg::SB_IDLE;
    end
    task automatic cycle(input logic p, input logic [31:0] b,
            input logic [7:0] s);
        @(posedge clk);
        portClk <= 1'b0;
        pipeN <= p;
        bus <= b;
        sba <= s;
        repeat (4) @(posedge clk);
        portClk <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic idle;
        @(posedge clk);
        portClk <= 1'b0;
        pipeN <= 1'b1;
        bus <= ~bus;
        sba <= agp_rq_pkg::SB_IDLE;
        repeat (6) @(posedge clk);
    endtask
endmodule // agp_master_model

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, busOut, mBus, busWire;
    logic pready, pslverr, portClk, mPipe, pipeOut, pipeOe, pipeWire;
    logic busOe, stbF, stbS, pullEn, grantN, err, flg;
    logic [7:0] sba;
    logic [2:0] stat;
    int mismatches = 0;
    int compares = 0;
    assign busWire = busOe ? busOut : mBus;
    assign pipeWire = pipeOe ? pipeOut : mPipe;
    always #5 clk = ~clk;
    agp_request_queue DUT (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portClk(portClk),
        .pipelinedRequestNIn(pipeWire), .pipelinedRequestNOut(pipeOut),
        .pipelinedRequestNOe(pipeOe), .portAddrDataBusIn(busWire),
        .portAddrDataBusOut(busOut), .portAddrDataBusOe(busOe),
        .upperStrobeFirst(stbF), .upperStrobeSecond(stbS),
        .sidebandAddrBus(sba), .sidebandPullupEn(pullEn),
        .portGrantN(grantN), .arbiterStatusCode(stat));
    agp_master_model MST (.clk(clk), .portClk(portClk), .pipeN(mPipe),
        .bus(mBus), .sba(sba));
    ////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        compares++;
        if (got !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic link;
        MST.cycle(1'b1, ~MST.bus, agp_rq_pkg::SB_IDLE);
        repeat (3) @(posedge clk);
    endtask
    task automatic sbw(input logic [31:0] w, input logic inv);
        for (int k = 0; k < 4; k++) begin
            MST.cycle(1'b1, 32'h0000_0000, w[8*k +: 8] ^ {8{inv}});
            if (k == 1) begin
                MST.cycle(1'b1, 32'h0000_0000, agp_rq_pkg::SB_IDLE);
            end
        end
        MST.idle();
    endtask
    task automatic tx(input logic [31:0] d, input logic [31:0] x,
            input logic fo, output logic f);
        int n;
        n = 0;
        wr(agp_rq_pkg::OFS_TXDATA, d);
        while (grantN !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            summarize();
        end
        chk(32'(stat), 32'h0000_0000);
        link();
        chk(busOut, x);
        chk(32'({busOe, stbF, stbS, pipeOe}), 32'({3'b110, fo}));
        f = pipeOut;
        link();
        chk(32'(busOe), 32'h0000_0000);
        link();
        chk(32'(grantN), 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #200_000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'({grantN, stat, pullEn, busOe}), 32'h0000_003C);
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0010);
        rdc(agp_rq_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        tx(32'h0F0F_0F0F, 32'h0F0F_0F0F, 1'b0, flg);
        for (int i = 0; i < 9; i++) begin
            MST.cycle(1'b0, 32'hA000_0000 + i, agp_rq_pkg::SB_IDLE);
        end
        MST.cycle(1'b1, 32'hBEEF_0000, 8'h5A);
        MST.idle();
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0068);
        for (int i = 0; i < 8; i++) begin
            rdc(agp_rq_pkg::OFS_QUEUE, 32'hA000_0000 + i);
        end
        rdc(agp_rq_pkg::OFS_QUEUE, 32'h0000_0000);
        wr(agp_rq_pkg::OFS_STATUS, 32'h0000_0040);
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0010);
        wr(agp_rq_pkg::OFS_CTRL, 32'h0000_0008);
        sbw(32'h4433_2211, 1'b0);
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0010);
        wr(agp_rq_pkg::OFS_CTRL, 32'h0000_001C);
        repeat (2) @(posedge clk);
        chk(32'(pullEn), 32'h0000_0001);
        sbw(32'h4433_2211, 1'b0);
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0081);
        rdc(agp_rq_pkg::OFS_QUEUE, 32'h4433_2211);
        wr(agp_rq_pkg::OFS_CTRL, 32'h0000_0000);
        rdc(agp_rq_pkg::OFS_CTRL, 32'h0000_001C);
        do_reset();
        wr(agp_rq_pkg::OFS_CTRL, 32'h0000_0009);
        MST.cycle(1'b0, 32'h1234_5678, agp_rq_pkg::SB_IDLE);
        rdc(agp_rq_pkg::OFS_RXDATA, 32'h1234_5678);
        sbw(32'h8765_4321, 1'b1);
        rdc(agp_rq_pkg::OFS_RXDATA, 32'hFFFF_0000);
        rdc(agp_rq_pkg::OFS_STATUS, 32'h0000_0081);
        rdc(agp_rq_pkg::OFS_QUEUE, 32'h8765_4321);
        tx(32'hFFFF_0000, 32'hFFFF_0000, 1'b1, flg);
        chk(32'(flg), 32'h0000_0000);
        wr(agp_rq_pkg::OFS_CTRL, 32'h0000_000B);
        tx(32'h00FF_1111, 32'h00FF_1111, 1'b1, flg);
        tx(32'hFF00_2222, 32'h00FF_2222, 1'b1, flg);
        tx(32'h00FF_3333, 32'h00FF_3333, 1'b1, err);
        chk(32'(flg ^ err), 32'h0000_0001);
        MST.cycle(1'b1, 32'h5555_AAAA, agp_rq_pkg::SB_IDLE);
        rdc(agp_rq_pkg::OFS_RXDATA, 32'hAAAA_AAAA);
        summarize();
    end
endmodule // tb
